// ---- rtl/tw_pkg.sv ----
package tw_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_MAX_KHZ = 400;
	localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
	// Least half period, rounded up to whole cycles
	localparam int HALF_CYC = (SCL_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

	// ****************************************
	// Packet layout
	// ****************************************
	localparam int ADDR_W = 7;
	localparam int NUM_ADDR = 1 << ADDR_W;
	localparam logic [ADDR_W-1:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] BIT_RST = 4'h0;
	localparam logic RW_READ = 1'b1;

	typedef enum logic [1:0]
	{
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h2,
		OP_STOP = 2'h3
	} tw_op_t;
endpackage : tw_pkg

// ---- rtl/tw_line_if.sv ----
`timescale 1ns/1ns
interface tw_line_if;
	logic sclSync;
	logic sdaSync;
	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;
	logic busBusy;

	modport mon
	(
		output sclSync, sdaSync, sclRise, sclFall, startDet, stopDet, busBusy
	);
	modport eng
	(
		input sclSync, sdaSync, sclRise, sclFall, startDet, stopDet, busBusy
	);
endinterface : tw_line_if

// ---- rtl/tw_line_monitor.sv ----
`timescale 1ns/1ns
module tw_line_monitor
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclIn,
	input wire logic sdaIn,
	tw_line_if.mon bus
);
	import tw_pkg::*;

	logic [2:0] sclPipe_q, sclPipe_d;
	logic [2:0] sdaPipe_q, sdaPipe_d;
	logic busy_q, busy_d;
	logic startNow, stopNow;

	// ****************************************
	// Sync and condition detect
	// ****************************************
	always_comb
	begin
		// Stage 0 feeds stage 1 only; edges seen between stages 1 and 2
		sclPipe_d = {sclPipe_q[1:0], sclIn};
		sdaPipe_d = {sdaPipe_q[1:0], sdaIn};
		// Data edge while clock high both samples
		startNow = sclPipe_q[1] && sclPipe_q[2] && sdaPipe_q[2] && !sdaPipe_q[1];
		stopNow = sclPipe_q[1] && sclPipe_q[2] && !sdaPipe_q[2] && sdaPipe_q[1];
		busy_d = busy_q;
		if (startNow)
			busy_d = 1'b1;
		else if (stopNow)
			busy_d = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			// Lines assumed released: idle bus after reset
			sclPipe_q <= 3'h7;
			sdaPipe_q <= 3'h7;
			busy_q <= 1'b0;
		end
		else
		begin
			sclPipe_q <= sclPipe_d;
			sdaPipe_q <= sdaPipe_d;
			busy_q <= busy_d;
		end
	end

	assign bus.sclSync = sclPipe_q[1];
	assign bus.sdaSync = sdaPipe_q[1];
	assign bus.sclRise = sclPipe_q[1] && !sclPipe_q[2];
	assign bus.sclFall = !sclPipe_q[1] && sclPipe_q[2];
	assign bus.startDet = startNow;
	assign bus.stopDet = stopNow;
	assign bus.busBusy = busy_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_busy_after_start;
		bus.startDet |=> busy_q;
	endproperty
	a_busy_after_start: assert property (p_busy_after_start) else $error("bus not busy after start");

	property p_repeat_keeps_busy;
		(busy_q && bus.startDet) |=> busy_q [*2];
	endproperty
	a_repeat_keeps_busy: assert property (p_repeat_keeps_busy) else $error("repeated start lost busy");

	property p_idle_after_stop;
		bus.stopDet |=> !busy_q;
	endproperty
	a_idle_after_stop: assert property (p_idle_after_stop) else $error("bus busy after stop");

	property p_start_clock_high;
		bus.startDet |-> bus.sclSync && !bus.sdaSync && $past(bus.sdaSync);
	endproperty
	a_start_clock_high: assert property (p_start_clock_high) else $error("start without high clock");

	c_start: cover property (bus.startDet);
	c_repeat: cover property (busy_q && bus.startDet);
endmodule : tw_line_monitor

// ---- rtl/tw_two_wire_interface.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Master starts, ends and clocks each transfer
// - Lines only pulled low or released
// - Line high only when all release
// - One clock pulse per data bit
// - Data steady while clock is high
// - Start/stop are data edges during high clock
// - Master opens with start, closes with stop
// - Busy from start until stop
// - Start while busy is repeated start
// - Seven-bit slave address space
// - Clock rate up to 400 kHz
// - Programmable own address, optional general call
// - Own address match raises wake pulse
// - Address packet: 7 bits, direction, acknowledge
// - Receiver acknowledges by pulling data low
// - All-zero address is general call
// - Data packet: byte MSB first, acknowledge
module tw_two_wire_interface
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire tw_pkg::tw_op_t cmdOp,
	input wire logic [7:0] cmdData,
	input wire logic cmdAck,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspAck,
	output logic busBusy,
	input wire logic slvEnable,
	input wire logic [tw_pkg::ADDR_W-1:0] ownAddr,
	input wire logic genCallEn,
	input wire logic slvAckEn,
	input wire logic [7:0] slvTxData,
	output logic slvTxLoad,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic wake
);
	import tw_pkg::*;

	typedef enum logic [9:0]
	{
		M_IDLE = 10'h001, M_REST = 10'h002, M_STA_HI = 10'h004, M_STA_LO = 10'h008,
		M_HOLD = 10'h010, M_BIT_LO = 10'h020, M_BIT_HI = 10'h040, M_STP_LO = 10'h080,
		M_STP_HI = 10'h100, M_STP_END = 10'h200
	} tw_mst_t;
	typedef enum logic [6:0]
	{
		S_IDLE = 7'h01, S_ADDR = 7'h02, S_ACK = 7'h04, S_RX = 7'h08,
		S_RXACK = 7'h10, S_TX = 7'h20, S_TXACK = 7'h40
	} tw_slv_t;

	tw_line_if bus ();

	tw_line_monitor u_mon
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.bus(bus)
	);

	function automatic logic [3:0] incBit(input logic [3:0] v);
		incBit = v + 4'h1;
	endfunction : incBit

	// ****************************************
	// Master
	// ****************************************
	tw_mst_t mstState_q, mstState_d;
	logic [CNT_W-1:0] mstCnt_q, mstCnt_d;
	logic [3:0] mstBit_q, mstBit_d;
	logic [8:0] txSh_q, txSh_d;
	logic [8:0] rxSh_q, rxSh_d;
	logic mstSclOe_q, mstSclOe_d, mstSdaOe_q, mstSdaOe_d;
	logic rspValid_q, rspValid_d, rspAck_q, rspAck_d;
	logic [7:0] rspData_q, rspData_d;
	logic halfDone, take;

	always_comb
	begin
		mstState_d = mstState_q;
		mstCnt_d = mstCnt_q + 8'h01;
		mstBit_d = mstBit_q;
		txSh_d = txSh_q;
		rxSh_d = rxSh_q;
		mstSclOe_d = mstSclOe_q;
		mstSdaOe_d = mstSdaOe_q;
		rspValid_d = 1'b0;
		rspAck_d = rspAck_q;
		rspData_d = rspData_q;
		halfDone = (mstCnt_q == HALF_CNT - 8'h01);
		// Only a free bus may be seized; repeated start only from own hold
		cmdReady = (mstState_q == M_HOLD) || (mstState_q == M_IDLE && !bus.busBusy);
		take = cmdValid && cmdReady;
		unique case (mstState_q)
			M_IDLE:
			begin
				mstCnt_d = CNT_RST;
				if (take && cmdOp == OP_START)
					mstState_d = M_STA_HI;
			end
			M_HOLD:
			begin
				mstCnt_d = CNT_RST;
				if (take)
				begin
					unique case (cmdOp)
						OP_START: mstState_d = M_REST;
						OP_STOP: mstState_d = M_STP_LO;
						OP_WRITE:
						begin
							txSh_d = {cmdData, 1'b1};
							mstState_d = M_BIT_LO;
						end
						OP_READ:
						begin
							txSh_d = {8'hff, ~cmdAck};
							mstState_d = M_BIT_LO;
						end
					endcase
					mstBit_d = BIT_RST;
				end
			end
			M_REST:
			begin
				mstSdaOe_d = 1'b0;
				if (halfDone)
				begin
					mstCnt_d = CNT_RST;
					mstState_d = M_STA_HI;
				end
			end
			M_STA_HI:
			begin
				mstSclOe_d = 1'b0;
				if (!bus.sclSync)
					mstCnt_d = CNT_RST;
				else if (halfDone)
				begin
					// Data falls while clock high
					mstSdaOe_d = 1'b1;
					mstCnt_d = CNT_RST;
					mstState_d = M_STA_LO;
				end
			end
			M_STA_LO:
			begin
				if (halfDone)
				begin
					mstSclOe_d = 1'b1;
					mstCnt_d = CNT_RST;
					mstState_d = M_HOLD;
				end
			end
			M_BIT_LO:
			begin
				// Data changes only with the clock held low
				mstSdaOe_d = ~txSh_q[8];
				if (halfDone)
				begin
					mstSclOe_d = 1'b0;
					mstCnt_d = CNT_RST;
					mstState_d = M_BIT_HI;
				end
			end
			M_BIT_HI:
			begin
				// Count high time only once the wired line is high: honours stretching
				if (!bus.sclSync)
					mstCnt_d = CNT_RST;
				else if (halfDone)
				begin
					mstSclOe_d = 1'b1;
					mstCnt_d = CNT_RST;
					rxSh_d = {rxSh_q[7:0], bus.sdaSync};
					txSh_d = {txSh_q[7:0], 1'b1};
					mstBit_d = incBit(mstBit_q);
					if (mstBit_q == DATA_BITS)
					begin
						rspValid_d = 1'b1;
						rspData_d = rxSh_q[7:0];
						rspAck_d = !bus.sdaSync;
						mstState_d = M_HOLD;
					end
					else
						mstState_d = M_BIT_LO;
				end
			end
			M_STP_LO:
			begin
				mstSdaOe_d = 1'b1;
				if (halfDone)
				begin
					mstSclOe_d = 1'b0;
					mstCnt_d = CNT_RST;
					mstState_d = M_STP_HI;
				end
			end
			M_STP_HI:
			begin
				if (!bus.sclSync)
					mstCnt_d = CNT_RST;
				else if (halfDone)
				begin
					// Data rises while clock high
					mstSdaOe_d = 1'b0;
					mstCnt_d = CNT_RST;
					mstState_d = M_STP_END;
				end
			end
			M_STP_END:
			begin
				// Bus free time before the next start
				if (halfDone)
				begin
					// Counter cleared so it never reaches the half count
					mstCnt_d = CNT_RST;
					mstState_d = M_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			mstState_q <= M_IDLE;
			mstCnt_q <= CNT_RST;
			mstBit_q <= BIT_RST;
			txSh_q <= 9'h1ff;
			rxSh_q <= 9'h000;
			mstSclOe_q <= 1'b0;
			mstSdaOe_q <= 1'b0;
			rspValid_q <= 1'b0;
			rspAck_q <= 1'b0;
			rspData_q <= 8'h00;
		end
		else
		begin
			mstState_q <= mstState_d;
			mstCnt_q <= mstCnt_d;
			mstBit_q <= mstBit_d;
			txSh_q <= txSh_d;
			rxSh_q <= rxSh_d;
			mstSclOe_q <= mstSclOe_d;
			mstSdaOe_q <= mstSdaOe_d;
			rspValid_q <= rspValid_d;
			rspAck_q <= rspAck_d;
			rspData_q <= rspData_d;
		end
	end

	// ****************************************
	// Slave
	// ****************************************
	tw_slv_t slvState_q, slvState_d;
	logic [3:0] slvCnt_q, slvCnt_d;
	logic [7:0] slvSh_q, slvSh_d;
	logic slvRw_q, slvRw_d, slvSdaOe_q, slvSdaOe_d;
	logic wake_q, wake_d, rxValid_q, rxValid_d, txLoad_q, txLoad_d;
	logic [7:0] rxData_q, rxData_d;
	logic ownHit, gcHit;

	always_comb
	begin
		slvState_d = slvState_q;
		slvCnt_d = slvCnt_q;
		slvSh_d = slvSh_q;
		slvRw_d = slvRw_q;
		slvSdaOe_d = slvSdaOe_q;
		wake_d = 1'b0;
		rxValid_d = 1'b0;
		txLoad_d = 1'b0;
		rxData_d = rxData_q;
		ownHit = (slvSh_q[7:1] == ownAddr);
		// General call with read direction never counts as a general-call hit (acked only if ownAddr is zero)
		gcHit = genCallEn && slvSh_q[7:1] == GEN_CALL_ADDR && slvSh_q[0] != RW_READ;
		if (bus.stopDet)
		begin
			slvState_d = S_IDLE;
			slvSdaOe_d = 1'b0;
		end
		else if (bus.startDet && slvEnable && mstState_q == M_IDLE)
		begin
			slvState_d = S_ADDR;
			slvCnt_d = BIT_RST;
			slvSdaOe_d = 1'b0;
		end
		else
		begin
			unique case (slvState_q)
				S_IDLE:
				begin
					slvSdaOe_d = 1'b0;
				end
				S_ADDR:
				begin
					if (bus.sclRise)
					begin
						slvSh_d = {slvSh_q[6:0], bus.sdaSync};
						slvCnt_d = incBit(slvCnt_q);
					end
					else if (bus.sclFall && slvCnt_q == DATA_BITS)
					begin
						if (ownHit || gcHit)
						begin
							slvState_d = S_ACK;
							slvSdaOe_d = 1'b1;
							slvRw_d = slvSh_q[0];
							wake_d = 1'b1;
						end
						else
							slvState_d = S_IDLE;
					end
				end
				S_ACK:
				begin
					if (bus.sclFall)
					begin
						slvCnt_d = BIT_RST;
						if (slvRw_q == RW_READ)
						begin
							slvState_d = S_TX;
							slvSh_d = slvTxData;
							slvSdaOe_d = ~slvTxData[7];
							txLoad_d = 1'b1;
						end
						else
						begin
							slvState_d = S_RX;
							slvSdaOe_d = 1'b0;
						end
					end
				end
				S_RX:
				begin
					if (bus.sclRise)
					begin
						slvSh_d = {slvSh_q[6:0], bus.sdaSync};
						slvCnt_d = incBit(slvCnt_q);
					end
					else if (bus.sclFall && slvCnt_q == DATA_BITS)
					begin
						rxValid_d = 1'b1;
						rxData_d = slvSh_q;
						slvSdaOe_d = slvAckEn;
						slvState_d = S_RXACK;
					end
				end
				S_RXACK:
				begin
					if (bus.sclFall)
					begin
						slvSdaOe_d = 1'b0;
						slvCnt_d = BIT_RST;
						slvState_d = S_RX;
					end
				end
				S_TX:
				begin
					if (bus.sclRise)
						slvCnt_d = incBit(slvCnt_q);
					else if (bus.sclFall)
					begin
						// Shift only after the clock is low again
						if (slvCnt_q == DATA_BITS)
						begin
							slvSdaOe_d = 1'b0;
							slvState_d = S_TXACK;
						end
						else
						begin
							slvSh_d = {slvSh_q[6:0], 1'b1};
							slvSdaOe_d = ~slvSh_q[6];
						end
					end
				end
				S_TXACK:
				begin
					if (bus.sclRise && bus.sdaSync)
						slvState_d = S_IDLE;
					else if (bus.sclFall)
					begin
						slvCnt_d = BIT_RST;
						slvState_d = S_TX;
						slvSh_d = slvTxData;
						slvSdaOe_d = ~slvTxData[7];
						txLoad_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			slvState_q <= S_IDLE;
			slvCnt_q <= BIT_RST;
			slvSh_q <= 8'h00;
			slvRw_q <= 1'b0;
			slvSdaOe_q <= 1'b0;
			wake_q <= 1'b0;
			rxValid_q <= 1'b0;
			txLoad_q <= 1'b0;
			rxData_q <= 8'h00;
		end
		else
		begin
			slvState_q <= slvState_d;
			slvCnt_q <= slvCnt_d;
			slvSh_q <= slvSh_d;
			slvRw_q <= slvRw_d;
			slvSdaOe_q <= slvSdaOe_d;
			wake_q <= wake_d;
			rxValid_q <= rxValid_d;
			txLoad_q <= txLoad_d;
			rxData_q <= rxData_d;
		end
	end

	// ****************************************
	// Pins and outputs
	// ****************************************
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = mstSclOe_q;
	assign sdaOe = mstSdaOe_q | slvSdaOe_q;
	assign rspValid = rspValid_q;
	assign rspData = rspData_q;
	assign rspAck = rspAck_q;
	assign busBusy = bus.busBusy;
	assign slvTxLoad = txLoad_q;
	assign rxValid = rxValid_q;
	assign rxData = rxData_q;
	assign wake = wake_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_half_bound;
		mstCnt_q < HALF_CNT;
	endproperty
	a_half_bound: assert property (p_half_bound) else $error("half period overrun");

	property p_data_stable;
		(mstState_q == M_BIT_HI && $past(mstState_q) == M_BIT_HI) |-> $stable(mstSdaOe_q);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved with clock high");

	property p_bit_per_pulse;
		(mstState_q == M_BIT_HI && mstState_d != M_BIT_HI)
			|=> mstSclOe_q && mstBit_q == incBit($past(mstBit_q));
	endproperty
	a_bit_per_pulse: assert property (p_bit_per_pulse) else $error("bit count not tied to pulse");

	property p_start_shape;
		(mstState_q == M_STA_HI && mstState_d == M_STA_LO)
			|=> mstSdaOe_q && !mstSclOe_q && bus.sclSync;
	endproperty
	a_start_shape: assert property (p_start_shape) else $error("start not made under high clock");

	property p_no_seize_busy;
		(mstState_q == M_IDLE && bus.busBusy) |=> mstState_q == M_IDLE;
	endproperty
	a_no_seize_busy: assert property (p_no_seize_busy) else $error("master seized busy bus");

	property p_idle_released;
		(mstState_q == M_IDLE && slvState_q == S_IDLE) |-> !sclOe && !sdaOe;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("idle block drives a line");

	property p_match_ack;
		(slvState_q == S_ADDR && slvState_d == S_ACK)
			|-> slvCnt_q == DATA_BITS ##1 wake_q && slvSdaOe_q;
	endproperty
	a_match_ack: assert property (p_match_ack) else $error("address match without ack and wake");

	property p_gc_only_zero;
		(slvState_q == S_ADDR && slvState_d == S_ACK && slvSh_q[7:1] != ownAddr)
			|-> genCallEn && slvSh_q[7:1] == GEN_CALL_ADDR;
	endproperty
	a_gc_only_zero: assert property (p_gc_only_zero) else $error("foreign address acknowledged");

	property p_stop_release;
		mstState_q == M_STP_END |-> !mstSdaOe_q && !mstSclOe_q;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("stop left a line driven");

	c_mst_byte: cover property (rspValid_q);
	c_slv_rx: cover property (rxValid_q);
	c_slv_tx: cover property (txLoad_q);
endmodule : tw_two_wire_interface

// ---- verification/tw_far_party.sv ----
`timescale 1ns/1ns
module tw_far_party
(
	input wire logic scl,
	input wire logic sda,
	output logic sclPull,
	output logic sdaPull
);
	// ********
	// Far slave
	// ********
	logic ackEn = 1'b1;
	logic ownM = 1'b0;
	logic sending = 1'b0;
	logic firstB = 1'b0;
	logic mAck = 1'b1;
	logic [7:0] txByte = 8'hc3;
	logic [7:0] shiftQ = 8'h00;
	logic [7:0] lastRx = 8'h00;
	int bitCnt = 0;

	initial
	begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
	end

	// Start or repeated start opens a fresh packet
	always @(negedge sda)
		if (scl && !ownM)
		begin
			// Clock fall closing the start carries no bit
			bitCnt = -1;
			firstB = 1'b1;
			sending = 1'b0;
		end

	always @(posedge sda)
		if (scl && !ownM)
			sending = 1'b0;

	always @(posedge scl)
		if (!ownM && bitCnt < 8)
			shiftQ = {shiftQ[6:0], sda};
		else if (!ownM && sending)
			mAck = sda;

	// Changes only while the clock is low, never during the high phase
	always @(negedge scl)
		if (!ownM)
		begin
			bitCnt = bitCnt + 1;
			if (bitCnt == 8)
			begin
				lastRx = shiftQ;
				sdaPull = (firstB || !sending) && ackEn;
			end
			else
			begin
				if (bitCnt == 9)
				begin
					bitCnt = 0;
					if (firstB)
						sending = lastRx[0];
					else if (mAck)
						sending = 1'b0;
					firstB = 1'b0;
				end
				sdaPull = sending && !txByte[7 - bitCnt];
			end
		end

	// ********
	// Far master, link clock runs only within frames
	// ********
	task automatic mStart();
		ownM = 1'b1;
		sdaPull = 1'b1;
		#63 sclPull = 1'b1;
		#62;
	endtask : mStart

	task automatic mXfer(input logic [7:0] b, input logic ackBit, output logic [7:0] got,
		output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			#31 sdaPull = !b[i];
			#31 sclPull = 1'b0;
			#32 got[i] = sda;
			#31 sclPull = 1'b1;
		end
		#31 sdaPull = ackBit;
		#31 sclPull = 1'b0;
		#32 ack = !sda;
		#31 sclPull = 1'b1;
	endtask : mXfer

	task automatic mStop();
		#31 sdaPull = 1'b1;
		#31 sclPull = 1'b0;
		#63 sdaPull = 1'b0;
		#65 ownM = 1'b0;
	endtask : mStop
endmodule : tw_far_party

// ---- verification/tb_two_wire_bus_conditions.sv ----
`timescale 1ns/1ns
`define CHK(a, b) \
	begin \
		nTests++; \
		if ((a) !== (b)) \
		begin \
			numErrors++; \
			$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module tb_two_wire_bus_conditions;
	import tw_pkg::*;
	typedef struct packed
	{
		logic fromFar;
		logic [6:0] addr;
		logic rw;
		logic [7:0] data;
		logic ackEn;
		logic expAck;
	} tw_row_t;
	logic sys_clk, reset, cmdValid, cmdAck, slvEnable, genCallEn, slvAckEn;
	tw_op_t cmdOp;
	logic [7:0] cmdData, slvTxData, rspData, rxData, wakeCnt, w0, got;
	logic [6:0] ownAddr;
	logic sclOut, sclOe, sdaOut, sdaOe, cmdReady, rspValid, rspAck, busBusy;
	logic slvTxLoad, rxValid, wake, farScl, farSda, sclLine, sdaLine, ack;
	logic [7:0] rxCnt, loadCnt, r0, l0;
	int numErrors = 0;
	int nTests = 0;
	time lastRise = 0;
	tw_row_t rows [7] = '{
		'{1'b0, 7'h2a, 1'b0, 8'h81, 1'b1, 1'b1},
		'{1'b0, 7'h7f, 1'b0, 8'h00, 1'b0, 1'b0},
		'{1'b1, 7'h33, 1'b0, 8'h4b, 1'b1, 1'b1},
		'{1'b1, 7'h33, 1'b0, 8'h5a, 1'b0, 1'b1},
		'{1'b1, 7'h12, 1'b0, 8'h4b, 1'b1, 1'b0},
		'{1'b1, 7'h00, 1'b0, 8'he7, 1'b1, 1'b1},
		'{1'b1, 7'h00, 1'b1, 8'he7, 1'b1, 1'b0}
	};

	// Wired-AND, pull-ups raise a released line
	assign sclLine = !((sclOe && !sclOut) || farScl);
	assign sdaLine = !((sdaOe && !sdaOut) || farSda);

	tw_two_wire_interface DUT (.sys_clk, .reset, .sclIn(sclLine), .sclOut, .sclOe,
		.sdaIn(sdaLine), .sdaOut, .sdaOe, .cmdValid, .cmdReady, .cmdOp, .cmdData, .cmdAck,
		.rspValid, .rspData, .rspAck, .busBusy, .slvEnable, .ownAddr, .genCallEn, .slvAckEn,
		.slvTxData, .slvTxLoad, .rxValid, .rxData, .wake);
	tw_far_party far (.scl(sclLine), .sda(sdaLine), .sclPull(farScl), .sdaPull(farSda));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		wakeCnt <= reset ? 8'h00 : wakeCnt + {7'h00, wake === 1'b1};
		rxCnt <= reset ? 8'h00 : rxCnt + {7'h00, rxValid === 1'b1};
		loadCnt <= reset ? 8'h00 : loadCnt + {7'h00, slvTxLoad === 1'b1};
	end

	// Device-made clock periods never beat the rate limit
	always @(posedge sclLine)
	begin
		if (!far.ownM && lastRise != 0)
			`CHK($time - lastRise >= 2500, 1'b1)
		lastRise = $time;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic doCmd(input tw_op_t op, input logic [7:0] d, input logic a);
		int i;
		@(posedge sys_clk);
		cmdOp <= op;
		cmdData <= d;
		cmdAck <= a;
		cmdValid <= 1'b1;
		i = 0;
		do
		begin
			@(negedge sys_clk);
			i++;
		end
		while (cmdReady !== 1'b1 && i < 9000);
		@(posedge sys_clk);
		cmdValid <= 1'b0;
		i = 0;
		do
		begin
			@(negedge sys_clk);
			i++;
		end
		while (((op == OP_WRITE || op == OP_READ) ? rspValid : cmdReady) !== 1'b1 && i < 9000);
		`CHK(i < 9000, 1'b1)
	endtask : doCmd

	task automatic runRow(input tw_row_t r);
		@(posedge sys_clk);
		slvAckEn <= r.ackEn;
		far.ackEn = r.ackEn;
		#2;
		w0 = wakeCnt;
		r0 = rxCnt;
		if (r.fromFar)
		begin
			far.mStart();
			`CHK({busBusy, cmdReady}, 2'h2)
			far.mXfer({r.addr, r.rw}, 1'b0, got, ack);
			`CHK(ack, r.expAck)
			if (r.expAck && !r.rw)
			begin
				far.mXfer(r.data, 1'b0, got, ack);
				`CHK(ack, r.ackEn)
			end
			far.mStop();
			`CHK(wakeCnt - w0, {7'h00, r.expAck})
			`CHK(rxCnt - r0, {7'h00, r.expAck && !r.rw})
			if (r.expAck && !r.rw)
				`CHK(rxData, r.data)
		end
		else
		begin
			doCmd(OP_START, 8'h00, 1'b0);
			`CHK(busBusy, 1'b1)
			doCmd(OP_WRITE, {r.addr, r.rw}, 1'b0);
			`CHK({rspAck, far.lastRx}, {r.ackEn, r.addr, r.rw})
			doCmd(OP_WRITE, r.data, 1'b0);
			`CHK({rspAck, far.lastRx, rspData}, {r.ackEn, r.data, r.data})
			doCmd(OP_STOP, 8'h00, 1'b0);
		end
		repeat (5) @(negedge sys_clk);
		`CHK(busBusy, 1'b0)
		$display("Row done, address %h", r.addr);
	endtask : runRow

	initial
	begin
		#1000000;
		numErrors++;
		conclude();
	end

	initial
	begin
		reset = 1'b1;
		cmdValid = 1'b0;
		cmdOp = OP_START;
		cmdData = 8'h00;
		cmdAck = 1'b0;
		slvEnable = 1'b0;
		ownAddr = 7'h33;
		genCallEn = 1'b1;
		slvAckEn = 1'b1;
		slvTxData = 8'h96;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		slvEnable <= 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK({sclOut, sdaOut, sclOe, sdaOe, busBusy, cmdReady}, 6'h01)
		$display("Reset test done");
		foreach (rows[k])
			runRow(rows[k]);
		// Device reads two bytes, acks only the first
		far.ackEn = 1'b1;
		doCmd(OP_START, 8'h00, 1'b0);
		doCmd(OP_WRITE, {7'h2a, RW_READ}, 1'b0);
		doCmd(OP_READ, 8'h00, 1'b1);
		`CHK({rspData, far.mAck}, {8'hc3, 1'b0})
		doCmd(OP_READ, 8'h00, 1'b0);
		`CHK({rspData, far.mAck}, {8'hc3, 1'b1})
		doCmd(OP_STOP, 8'h00, 1'b0);
		$display("Read test done");
		// Repeated start keeps the bus held
		doCmd(OP_START, 8'h00, 1'b0);
		doCmd(OP_WRITE, 8'h54, 1'b0);
		doCmd(OP_START, 8'h00, 1'b0);
		`CHK(busBusy, 1'b1)
		doCmd(OP_WRITE, 8'h2a, 1'b0);
		`CHK({rspAck, far.lastRx}, {1'b1, 8'h2a})
		doCmd(OP_STOP, 8'h00, 1'b0);
		repeat (5) @(negedge sys_clk);
		`CHK(busBusy, 1'b0)
		$display("Repeated start test done");
		// Far master reads the device slave
		@(posedge sys_clk);
		#2 l0 = loadCnt;
		far.mStart();
		far.mXfer({7'h33, RW_READ}, 1'b0, got, ack);
		`CHK(ack, 1'b1)
		far.mXfer(8'hff, 1'b0, got, ack);
		`CHK(got, 8'h96)
		far.mStop();
		`CHK(loadCnt - l0, 8'h01)
		$display("Slave read test done");
		conclude();
	end
endmodule : tb_two_wire_bus_conditions
